// ---- hdl/pm_config_loader.sv ----
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pm_loader_cfg.svh"

module pm_config_loader
  import pm_loader_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // word fetch from the nonvolatile store
  output logic                    nvmReq,
  output logic [7:0]              nvmAddr,
  input  wire logic               nvmAck,
  input  wire logic [15:0]        nvmData,
  // avalon-mm slave, address = {port, config offset}
  input  wire logic [9:0]         avsAddress,
  input  wire logic               avsRead,
  input  wire logic               avsWrite,
  input  wire logic [31:0]        avsWritedata,
  input  wire logic [3:0]         avsByteenable,
  output logic [31:0]             avsReaddata,
  output logic                    avsWaitrequest,
  // loaded configuration towards the ports
  output port_cfg_t [3:0]         portCfg,
  output logic                    loadDone
);

  logic [1:0]  rstSync_ff;
  logic        rstn;
  ld_state_t   state_ff;
  ld_state_t   nxt_state;
  logic [3:0]  idx_ff;
  logic [3:0]  nxt_idx;
  logic        nvmReq_ff;
  logic [7:0]  nvmAddr_ff;
  logic        loadDone_ff;
  logic        waitreq_ff;
  logic [31:0] readdata_ff;
  port_cfg_t   cfg_ff [`NUM_PORTS];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rstSync_ff <= 2'b00;
    else         rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstn = rstSync_ff[1];

  // ---------------- load sequencer ----------------
  // words are fetched in index order: 4 phy, 4 capability, 4 power data;
  // port number is the low two index bits since each group is 4 long
  word_kind_t  curKind;
  logic [1:0]  curPort;
  logic [7:0]  curBase;
  logic [7:0]  curAddr;
  logic        loadHit;
  logic        isPhy;
  logic        isCap;
  logic        isData;

  assign curPort = idx_ff[1:0];
  assign curKind = (idx_ff[3:2] == 2'b00) ? W_PHY :
                   (idx_ff[3:2] == 2'b01) ? W_CAP : W_DATA;
  assign isPhy   = (curKind == W_PHY);
  assign isCap   = (curKind == W_CAP);
  assign isData  = (curKind == W_DATA);
  assign curBase = isPhy ? `LD_PHY_BASE :
                   isCap ? `LD_CAP_BASE : `LD_DATA_BASE;
  assign curAddr = curBase + {5'b00000, curPort, 1'b0}; // R6 R13 R14
  assign loadHit = (state_ff == LD_WAIT) && nvmAck;

  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    case (state_ff)
      LD_REQ:  nxt_state = LD_WAIT;
      LD_WAIT: begin
        if (nvmAck) begin
          nxt_idx   = idx_ff + 4'h1;
          nxt_state = (idx_ff == `LD_LAST) ? LD_DONE : LD_REQ; // R15
        end
      end
      LD_DONE: nxt_state = LD_DONE;
      default: nxt_state = LD_REQ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= LD_REQ;
      idx_ff      <= 4'h0;
      nvmReq_ff   <= 1'b0;
      nvmAddr_ff  <= 8'h00;
      loadDone_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      idx_ff      <= nxt_idx;
      nvmReq_ff   <= (nxt_state == LD_WAIT);
      nvmAddr_ff  <= (state_ff == LD_REQ) ? curAddr : nvmAddr_ff;
      loadDone_ff <= (nxt_state == LD_DONE); // R15
    end
  end

  // ---------------- avalon slave ----------------
  // one cycle with waitrequest low per access; held off until load is done
  logic [1:0]  busPort;
  logic [7:0]  busOff;
  logic        busReq;
  logic        busWr;
  logic        busAccept;
  port_cfg_t   busCfg;
  logic [31:0] rdPmCap;
  logic [31:0] rdPmCsr;
  logic [31:0] rdValue;

  assign busPort   = avsAddress[9:8];
  assign busOff    = avsAddress[7:0];
  assign busReq    = avsRead || avsWrite;
  assign busAccept = busReq && waitreq_ff && loadDone_ff; // R15
  assign busWr     = avsWrite && !waitreq_ff;
  assign busCfg    = cfg_ff[busPort];

  assign rdPmCap = {2'b00, busCfg.pmeSupport, 1'b0, 1'b1, 1'b1, // R9 R10
                    busCfg.auxCurrent, 22'h000000};
  assign rdPmCsr = {busCfg.powerData, 20'h00000, busCfg.noSoftReset, 3'b000};

  // bits of these dwords not fed by any loader word read as zero here, except dword 40h bits 25 and 26 (D1, D2) which read as one
  always_comb begin
    case (busOff)
      `OFF_PMCAP:   rdValue = rdPmCap;
      `OFF_PMCSR:   rdValue = rdPmCsr;
      `OFF_LINKCTL: rdValue = {20'h00000, busCfg.complianceToDetect, 11'h000};
      `OFF_PHY2:    rdValue = {19'h00000, busCfg.phyParam2, 8'h00};
      `OFF_CHGCNT:  rdValue = {22'h000000, busCfg.dataChangeCountSelect,
                               8'h00};
      `OFF_PHY3:    rdValue = {25'h0000000, busCfg.phyParam3};
      `OFF_DEEMPH:  rdValue = {25'h0000000, busCfg.deemphSel, 6'h00};
      default:      rdValue = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else begin
      waitreq_ff  <= !busAccept;
      readdata_ff <= busAccept ? rdValue : readdata_ff;
    end
  end

  // ---------------- per-port configuration bits ----------------
  // capability and power data bits are read-only; phy tuning stays writable
  genvar p;
  generate
    for (p = 0; p < `NUM_PORTS; p++) begin : g_port
      logic ldHere;
      logic wrHere;
      assign ldHere = loadHit && (curPort == p[1:0]);
      assign wrHere = busWr && (busPort == p[1:0]);

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cfg_ff[p] <= `CFG_RESET; // R16
        end else if (ldHere && isPhy) begin
          cfg_ff[p].phyParam2             <= nvmData[4:0]; // R1
          cfg_ff[p].phyParam3             <= nvmData[11:5]; // R2
          cfg_ff[p].deemphSel             <= nvmData[12]; // R3
          cfg_ff[p].complianceToDetect    <= nvmData[13]; // R4
          cfg_ff[p].dataChangeCountSelect <= nvmData[15:14]; // R5
        end else if (ldHere && isCap) begin
          cfg_ff[p].noSoftReset <= nvmData[0]; // R7
          cfg_ff[p].auxCurrent  <= nvmData[3:1]; // R8
          cfg_ff[p].pmeSupport  <= nvmData[7:6]; // R11
        end else if (ldHere && isData) begin
          cfg_ff[p].powerData <= nvmData[15:8]; // R12
        end else if (wrHere) begin
          if (busOff == `OFF_PHY2 && avsByteenable[1])
            cfg_ff[p].phyParam2 <= avsWritedata[12:8];
          if (busOff == `OFF_PHY3 && avsByteenable[0])
            cfg_ff[p].phyParam3 <= avsWritedata[6:0];
          if (busOff == `OFF_DEEMPH && avsByteenable[0])
            cfg_ff[p].deemphSel <= avsWritedata[6];
          if (busOff == `OFF_LINKCTL && avsByteenable[1])
            cfg_ff[p].complianceToDetect <= avsWritedata[11];
          if (busOff == `OFF_CHGCNT && avsByteenable[1])
            cfg_ff[p].dataChangeCountSelect <= avsWritedata[9:8];
        end
      end
      assign portCfg[p] = cfg_ff[p];
    end
  endgenerate

  assign nvmReq         = nvmReq_ff;
  assign nvmAddr        = nvmAddr_ff;
  assign avsReaddata    = readdata_ff;
  assign avsWaitrequest = waitreq_ff;
  assign loadDone       = loadDone_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence phyLoad;
    loadHit && isPhy;
  endsequence

  sequence capLoad;
    loadHit && isCap;
  endsequence

  phy_param2_a: assert property ( // R1
    phyLoad |=> cfg_ff[$past(curPort)].phyParam2 == $past(nvmData[4:0]))
    else $error("phy parameter 2 not copied");

  phy_param3_a: assert property ( // R2
    phyLoad |=> cfg_ff[$past(curPort)].phyParam3 == $past(nvmData[11:5]))
    else $error("phy parameter 3 not copied");

  deemph_copy_a: assert property ( // R3
    phyLoad |=> cfg_ff[$past(curPort)].deemphSel == $past(nvmData[12]))
    else $error("de-emphasis bit not copied");

  compliance_copy_a: assert property ( // R4
    phyLoad |=> cfg_ff[$past(curPort)].complianceToDetect ==
                $past(nvmData[13]))
    else $error("compliance bit not copied");

  chg_cnt_copy_a: assert property ( // R5
    phyLoad |=> cfg_ff[$past(curPort)].dataChangeCountSelect ==
                $past(nvmData[15:14]))
    else $error("data change count select not copied");

  phy_addr_a: assert property ( // R6
    (state_ff == LD_WAIT) && isPhy && curPort[1] |->
      nvmAddr_ff == (curPort[0] ? 8'h46 : 8'h44))
    else $error("phy word fetched from wrong address");

  cap_fields_a: assert property ( // R7 R8 R11
    capLoad |=> {cfg_ff[$past(curPort)].pmeSupport,
                 cfg_ff[$past(curPort)].auxCurrent,
                 cfg_ff[$past(curPort)].noSoftReset} ==
                {$past(nvmData[7:6]), $past(nvmData[3:0])})
    else $error("capability word not copied");

  power_data_a: assert property ( // R12
    loadHit && isData |=>
      cfg_ff[$past(curPort)].powerData == $past(nvmData[15:8]))
    else $error("power data not copied");

  pm_addr_a: assert property ( // R13 R14
    (state_ff == LD_WAIT) && !isPhy && curPort != 2'b11 |->
      nvmAddr_ff == 8'h50 + {5'b00000, curPort, isData})
    else $error("pm word fetched from wrong address");

  d_states_a: assert property ( // R9 R10
    avsRead && waitreq_ff && loadDone_ff && busOff == `OFF_PMCAP |=>
      !avsWaitrequest && avsReaddata[26:25] == 2'b11)
    else $error("d1 or d2 support not read as one");

  load_gate_a: assert property ( // R15
    !loadDone_ff |=> avsWaitrequest)
    else $error("bus answered before load finished");

  ro_kept_a: assert property ( // R16
    busWr && (busOff == `OFF_PMCAP || busOff == `OFF_PMCSR) |=>
      $stable(cfg_ff[$past(busPort)]))
    else $error("read-only bits changed by write");

endmodule : pm_config_loader
`default_nettype wire

// ---- hdl/pm_loader_cfg.svh ----
// What this block does
// R1 - Each port's PHY tuning word bits 4:0 go to bits 12:8 of its dword 7Ch.
// R2 - PHY tuning word bits 11:5 go to bits 6:0 of the port's dword 90h.
// R3 - PHY tuning word bit 12 goes to bit 6 of dword F0h (de-emphasis).
// R4 - PHY tuning word bit 13 goes to bit 11 of dword 78h (compliance).
// R5 - PHY tuning word bits 15:14 go to bits 9:8 of dword 8Ch.
// R6 - Port 2 PHY tuning word comes from load address 44h, port 3 from 46h.
// R7 - Power-management word bit 0 goes to bit 3 of dword 44h.
// R8 - Power-management word bits 3:1 go to bits 24:22 of dword 40h.
// R9 - Dword 40h bit 25 (D1 support) reads as a fixed 1.
// R10 - Dword 40h bit 26 (D2 support) reads as a fixed 1.
// R11 - Power-management word bits 7:6 go to bits 29:28 of dword 40h.
// R12 - Power data word bits 15:8 go to read-only bits 31:24 of dword 44h.
// R13 - Capability words for ports 0, 1, 2 come from 50h, 52h, 54h.
// R14 - Power data words for ports 0, 1, 2 come from 51h, 53h, 55h.
// R15 - All words load after reset before the bits are readable; portCfg shows each bit as soon as its word loads.
// R16 - Unloaded bits keep defaults and read-only bits ignore writes.
`ifndef PM_LOADER_CFG_SVH
`define PM_LOADER_CFG_SVH

`define NUM_PORTS      4
`define LD_WORDS       4'hc
`define LD_LAST        4'hb
`define LD_PHY_BASE    8'h40
`define LD_CAP_BASE    8'h50
`define LD_DATA_BASE   8'h51

`define OFF_PMCAP      8'h40
`define OFF_PMCSR      8'h44
`define OFF_LINKCTL    8'h78
`define OFF_PHY2       8'h7c
`define OFF_CHGCNT     8'h8c
`define OFF_PHY3       8'h90
`define OFF_DEEMPH     8'hf0

`define POS_PHY2       8
`define POS_NSR        3
`define POS_AUX        22
`define POS_D1         25
`define POS_D2         26
`define POS_PME        28
`define POS_PDATA      24
`define POS_COMP       11
`define POS_CHGCNT     8
`define POS_DEEMPH     6

`define CFG_RESET      27'h0000000

`endif

// ---- hdl/pm_loader_pkg.sv ----
package pm_loader_pkg;

  typedef enum logic [1:0] {
    LD_REQ  = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } ld_state_t;

  typedef enum logic [1:0] {
    W_PHY  = 2'b00,
    W_CAP  = 2'b01,
    W_DATA = 2'b10
  } word_kind_t;

  // loaded bits of one port's configuration space
  typedef struct packed {
    logic [4:0] phyParam2;
    logic [6:0] phyParam3;
    logic       deemphSel;
    logic       complianceToDetect;
    logic [1:0] dataChangeCountSelect;
    logic       noSoftReset;
    logic [2:0] auxCurrent;
    logic [1:0] pmeSupport;
    logic [7:0] powerData;
  } port_cfg_t;

endpackage : pm_loader_pkg

// ---- testbench/nvm_word_store.sv ----
`timescale 1ns/1ps
`default_nettype none

module nvm_word_store (
  input  wire logic        ref_clk,
  input  wire logic        nvmReq,
  input  wire logic [7:0]  nvmAddr,
  output logic             nvmAck,
  output logic [15:0]      nvmData
);
  int waitCnt;

  initial begin
    nvmAck  = 1'b0;
    nvmData = 16'h0000;
    waitCnt = 0;
  end

  // words at bit1=1 slots answer at once, the others stall two cycles
  always @(posedge ref_clk) begin
    nvmAck  <= 1'b0;
    nvmData <= ~nvmData; // no stale word outside an acknowledge
    if (nvmReq && !nvmAck) begin
      if (waitCnt >= (nvmAddr[1] ? 0 : 2)) begin
        nvmAck  <= 1'b1;
        nvmData <= {~nvmAddr, nvmAddr + 8'h37};
        waitCnt <= 0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule : nvm_word_store

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import pm_loader_pkg::*;
;
  localparam logic [7:0] OFFS [7] = '{8'h40, 8'h44, 8'h78, 8'h7c, 8'h8c,
                                      8'h90, 8'hf0};
  logic            ref_clk, resetn, nvmReq, nvmAck, loadDone;
  logic            avsRead, avsWrite, avsWaitrequest;
  logic [7:0]      nvmAddr;
  logic [15:0]     nvmData;
  logic [9:0]      avsAddress;
  logic [31:0]     avsWritedata, avsReaddata, rd;
  logic [3:0]      avsByteenable;
  port_cfg_t [3:0] portCfg;
  int              n_fail, samples_checked;

  pm_config_loader pm_config_loader_inst (.ref_clk(ref_clk),
    .resetn(resetn), .nvmReq(nvmReq), .nvmAddr(nvmAddr), .nvmAck(nvmAck),
    .nvmData(nvmData), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .portCfg(portCfg), .loadDone(loadDone));

  nvm_word_store nvm_word_store_inst (.ref_clk(ref_clk), .nvmReq(nvmReq),
    .nvmAddr(nvmAddr), .nvmAck(nvmAck), .nvmData(nvmData));

  function automatic logic [15:0] nvword(input logic [7:0] a);
    return {~a, a + 8'h37};
  endfunction : nvword

  function automatic logic [31:0] expv(input int p, input logic [7:0] off);
    logic [15:0] w, c, d;
    w = nvword(8'h40 + 8'(2 * p));
    c = nvword(8'h50 + 8'(2 * p));
    d = nvword(8'h51 + 8'(2 * p));
    case (off)
      8'h7c: return {19'h0, w[4:0], 8'h00};
      8'h90: return {25'h0, w[11:5]};
      8'hf0: return {25'h0, w[12], 6'h00};
      8'h78: return {20'h0, w[13], 11'h000};
      8'h8c: return {22'h0, w[15:14], 8'h00};
      8'h40: return {2'b00, c[7:6], 1'b0, 2'b11, c[3:1], 22'h0};
      8'h44: return {d[15:8], 20'h0, c[0], 3'h0};
      default: return 32'h0;
    endcase
  endfunction : expv

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // one bus access, held until waitrequest is seen low at a rising edge
  task automatic access(input logic wr, input logic [1:0] port,
                        input logic [7:0] off, input logic [31:0] wdata,
                        input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avsAddress    <= {port, off};
    avsRead       <= !wr;
    avsWrite      <= wr;
    avsWritedata  <= wdata;
    avsByteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 3000);
    rd = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    if (avsWaitrequest !== 1'b0) begin
      check("bus wait", 32'h1, 32'h0);
      results();
    end
  endtask : access

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    check("run length", 32'h1, 32'h0);
    results();
  end

  initial begin
    resetn = 1'b0;
    {avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = '0;
    repeat (6) @(posedge ref_clk);
    check("fetch in reset", {31'h0, nvmReq}, 32'h0);
    check("done in reset", {31'h0, loadDone}, 32'h0);
    resetn <= 1'b1;
    access(1'b0, 2'd0, 8'h44, 32'h0, 4'hf);
    check("stalled read", rd, expv(0, 8'h44));
    check("done at answer", {31'h0, loadDone}, 32'h1);
    $display("test load-stall done");
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 7; i++) begin
        access(1'b0, 2'(p), OFFS[i], 32'h0, 4'hf);
        check($sformatf("p%0d off %h", p, OFFS[i]), rd, expv(p, OFFS[i]));
      end
      check($sformatf("portCfg %0d", p), {5'h0, portCfg[p]},
            {5'h0, expv(p, 8'h7c)[12:8], expv(p, 8'h90)[6:0],
             expv(p, 8'hf0)[6], expv(p, 8'h78)[11], expv(p, 8'h8c)[9:8],
             expv(p, 8'h44)[3], expv(p, 8'h40)[24:22],
             expv(p, 8'h40)[29:28], expv(p, 8'h44)[31:24]});
    end
    $display("test load map done");
    for (int i = 0; i < 2; i++) begin
      access(1'b1, 2'd2, OFFS[i], 32'hffff_ffff, 4'hf);
      access(1'b0, 2'd2, OFFS[i], 32'h0, 4'hf);
      check("read-only dword", rd, expv(2, OFFS[i]));
    end
    access(1'b1, 2'd1, 8'h7c, 32'hffff_ffff, 4'b0010);
    access(1'b1, 2'd1, 8'h7c, 32'h0000_0000, 4'b1101);
    access(1'b0, 2'd1, 8'h7c, 32'h0, 4'hf);
    check("lane write", rd, 32'h0000_1f00);
    access(1'b1, 2'd3, 8'h48, 32'hffff_ffff, 4'hf);
    access(1'b0, 2'd3, 8'h48, 32'h0, 4'hf);
    check("unmapped", rd, 32'h0);
    $display("test writes done");
    results();
  end
endmodule : tb_top

`default_nettype wire
